// ==== tone_sound_generator_config.sv ====
// Tone sound generator: Avalon-MM registers, prescaler, tone, PWM, envelope
//
// Contract
// - Enable low resets all counters and stops clocking the generator.
// - Mixing bit 0 gives tone gated by amplitude PWM, 1 gives tone only.
// - Data-ready bit shows programmed values may be copied into buffers.
// - Any configuration register write clears the data-ready bit.
// - Reload event with data-ready clear stops generation instead of reloading.
// - Halt bit at 1 stops generation at once, without waiting for edges.
// - Envelope enable bit switches automatic attack or decay on.
// - Shape field selects linear, gong or exponential; code three is reserved.
// - Direction bit 0 rises amplitude, 1 lowers it.
// - Prescaler divides clock by value plus one to step tone counter.
// - PWM period equals prescaler value plus one clocks.
// - Tone toggles every tone value plus one prescaler ticks.
// - PWM high time equals working amplitude clocks per period.
// - Amplitude at or above period length gives full duty.
// - Gong attack from zero amplitude stays zero forever.
// - Buffers reload synchronously at a tone edge.
// - Duration lasts value plus one tone cycles, then reloads or stops, or steps the envelope while its threshold is not reached.
// - Reload copies amplitude into working copy; envelope changes only that.
// - Next-data flag sets on load or stop; write one clears it.
`timescale 1ns/100ps
`default_nettype none
module tone_sound_generator_config (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RST_B_I,
    // Avalon-MM slave
    input wire tsg_pkg::av_req_s AV_REQ_I,
    output logic [31:0] AV_READDATA_O,
    output logic AV_WAITREQUEST_O,
    // Sound outputs
    output logic TONE_O,
    output logic AMP_O
);
    import tsg_pkg::*;

    logic wait_q;
    logic [31:0] rdata_q;
    logic enable_q;
    logic mix_q;
    logic data_ready_q;
    logic halt_q;
    logic next_flag_q;
    cfg_s prog_q;
    cfg_s buf_q;
    logic [10:0] work_amp_q;
    logic [10:0] pre_cnt_q;
    logic [9:0] tone_cnt_q;
    logic [7:0] dur_cnt_q;
    logic tone_q;
    gen_state_e state_q;
    logic tone_o_q;
    logic amp_o_q;
    logic [7:0] rd_byte;

    // Bus decode
    logic acc;
    logic wr;
    logic cfg_wr;
    logic [7:0] wbyte;
    assign acc = (AV_REQ_I.read || AV_REQ_I.write) && !wait_q;
    assign wr = acc && AV_REQ_I.write && AV_REQ_I.byteenable[0];
    assign wbyte = AV_REQ_I.writedata[7:0];
    assign cfg_wr = wr && (AV_REQ_I.address >= IDX_ENV) && (AV_REQ_I.address <= IDX_DUR);

    // Generator timing
    logic run;
    logic pre_tick;
    logic tone_edge;
    logic cycle_end;
    logic dur_end;
    logic thr_hit;
    logic reload_evt;
    logic start;
    logic load_evt;
    logic stop_evt;
    logic pwm_hi;

    assign run = (state_q == ST_RUN) && enable_q && !halt_q;
    assign pre_tick = run && (pre_cnt_q == buf_q.ps);
    assign tone_edge = pre_tick && (tone_cnt_q == buf_q.tone);
    assign cycle_end = tone_edge && tone_q;
    assign dur_end = cycle_end && (dur_cnt_q == buf_q.dur);
    assign thr_hit = buf_q.env_dir ? (work_amp_q <= buf_q.thr) : (work_amp_q >= buf_q.thr);
    // reload only at a tone edge
    assign reload_evt = dur_end && (!buf_q.env_en || thr_hit);
    assign start = (state_q == ST_IDLE) && enable_q && !halt_q && data_ready_q;
    assign load_evt = start || (reload_evt && data_ready_q);
    assign stop_evt = reload_evt && !data_ready_q;
    // high for amplitude clocks; full duty falls out of the compare
    assign pwm_hi = pre_cnt_q < work_amp_q;

    // Next working amplitude for one envelope step
    function automatic logic [10:0] env_step(input cfg_s c, input logic [10:0] a);
        logic [11:0] s;
        logic [10:0] room;
        s = {1'b0, a};
        room = AMP_MAX - a;
        unique case (c.env_shape)
            SHAPE_LINEAR: begin
                if (c.env_dir) begin
                    s = (a > c.step) ? ({1'b0, a} - {1'b0, c.step}) : 12'h000;
                end else begin
                    s = {1'b0, a} + {1'b0, c.step};
                end
            end
            // half-step growth keeps zero at zero
            SHAPE_GONG: begin
                if (c.env_dir) begin
                    s = {1'b0, a - {1'b0, a[10:1]}};
                end else begin
                    s = {1'b0, a} + {2'b00, a[10:1]};
                end
            end
            SHAPE_EXP: begin
                if (c.env_dir) begin
                    s = {1'b0, a - {2'b00, a[10:2]}};
                end else begin
                    s = {1'b0, a} + {3'b000, room[10:2]};
                end
            end
            // Reserved code holds the amplitude
            default: begin
                s = {1'b0, a};
            end
        endcase
        return (s > {1'b0, AMP_MAX}) ? AMP_MAX : s[10:0];
    endfunction : env_step

    // Avalon handshake: one wait cycle, then one cycle with waitrequest low
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            wait_q <= 1'b1;
        end else if ((AV_REQ_I.read || AV_REQ_I.write) && wait_q) begin
            wait_q <= 1'b0;
        end else begin
            wait_q <= 1'b1;
        end
    end

    // Read mux; unmapped and reserved locations read zero
    always_comb begin
        rd_byte = 8'h00;
        unique case (AV_REQ_I.address)
            IDX_CTRL: rd_byte = {enable_q, 4'h0, mix_q, data_ready_q, halt_q};
            IDX_ENV: rd_byte = {prog_q.env_en, 4'h0, prog_q.env_shape, prog_q.env_dir};
            IDX_PSH: rd_byte = {5'h00, prog_q.ps[10:8]};
            IDX_PSL: rd_byte = prog_q.ps[7:0];
            IDX_TONEH: rd_byte = {6'h00, prog_q.tone[9:8]};
            IDX_TONEL: rd_byte = prog_q.tone[7:0];
            IDX_AMPH: rd_byte = {5'h00, prog_q.amp[10:8]};
            IDX_AMPL: rd_byte = prog_q.amp[7:0];
            IDX_STEPH: rd_byte = {5'h00, prog_q.step[10:8]};
            IDX_STEPL: rd_byte = prog_q.step[7:0];
            IDX_THRH: rd_byte = {5'h00, prog_q.thr[10:8]};
            IDX_THRL: rd_byte = prog_q.thr[7:0];
            IDX_DUR: rd_byte = prog_q.dur;
            IDX_NEXT: rd_byte = {7'h00, next_flag_q};
            IDX_WAMPH: rd_byte = {5'h00, work_amp_q[10:8]};
            IDX_WAMPL: rd_byte = work_amp_q[7:0];
            IDX_DCNT: rd_byte = dur_cnt_q;
            default: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            rdata_q <= RDATA_RESET;
        end else if ((AV_REQ_I.read || AV_REQ_I.write) && wait_q) begin
            rdata_q <= {24'h00_0000, rd_byte};
        end
    end

    // Control register
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            enable_q <= CTRL_RESET;
            mix_q <= CTRL_RESET;
            halt_q <= CTRL_RESET;
        end else if (wr && AV_REQ_I.address == IDX_CTRL) begin
            enable_q <= wbyte[BIT_ENABLE];
            mix_q <= wbyte[BIT_MIX];
            halt_q <= wbyte[BIT_HALT];
        end
    end

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            data_ready_q <= CTRL_RESET;
        end else if (cfg_wr) begin
            data_ready_q <= 1'b0;
        // software marks the next sound ready
        end else if (wr && AV_REQ_I.address == IDX_CTRL) begin
            data_ready_q <= wbyte[BIT_READY];
        end
    end

    // Programmed configuration
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            prog_q <= CFG_RESET;
        end else if (wr) begin
            unique case (AV_REQ_I.address)
                IDX_ENV: begin
                    prog_q.env_en <= wbyte[BIT_ENV_EN];
                    prog_q.env_shape <= wbyte[BIT_SHAPE_LO +: 2];
                    prog_q.env_dir <= wbyte[BIT_ENV_DIR];
                end
                IDX_PSH: prog_q.ps[10:8] <= wbyte[2:0];
                IDX_PSL: prog_q.ps[7:0] <= wbyte;
                IDX_TONEH: prog_q.tone[9:8] <= wbyte[1:0];
                IDX_TONEL: prog_q.tone[7:0] <= wbyte;
                IDX_AMPH: prog_q.amp[10:8] <= wbyte[2:0];
                IDX_AMPL: prog_q.amp[7:0] <= wbyte;
                IDX_STEPH: prog_q.step[10:8] <= wbyte[2:0];
                IDX_STEPL: prog_q.step[7:0] <= wbyte;
                IDX_THRH: prog_q.thr[10:8] <= wbyte[2:0];
                IDX_THRL: prog_q.thr[7:0] <= wbyte;
                IDX_DUR: prog_q.dur <= wbyte;
                default: prog_q <= prog_q;
            endcase
        end
    end

    // hardware set wins over a same-cycle clear
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            next_flag_q <= CTRL_RESET;
        end else if (load_evt || stop_evt) begin
            next_flag_q <= 1'b1;
        end else if (wr && AV_REQ_I.address == IDX_NEXT && wbyte[BIT_NEXT]) begin
            next_flag_q <= 1'b0;
        end
    end

    // Generator state
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            state_q <= ST_IDLE;
        // disable and halt act at once
        end else if (!enable_q || halt_q) begin
            state_q <= ST_IDLE;
        end else begin
            unique case (state_q)
                ST_IDLE: if (start) state_q <= ST_RUN;
                ST_RUN: if (stop_evt) state_q <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            buf_q <= CFG_RESET;
        end else if (load_evt) begin
            buf_q <= prog_q;
        end
    end

    // working amplitude; envelope never touches the programmed value
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            work_amp_q <= 11'h000;
        end else if (load_evt) begin
            work_amp_q <= prog_q.amp;
        end else if (dur_end && buf_q.env_en && !thr_hit) begin
            work_amp_q <= env_step(buf_q, work_amp_q);
        end
    end

    // counters held at zero whenever not running
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            pre_cnt_q <= 11'h000;
        end else if (!run || pre_tick) begin
            pre_cnt_q <= 11'h000;
        end else begin
            pre_cnt_q <= pre_cnt_q + 11'h001;
        end
    end

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            tone_cnt_q <= 10'h000;
            tone_q <= 1'b0;
        end else if (!run) begin
            tone_cnt_q <= 10'h000;
            tone_q <= 1'b0;
        end else if (tone_edge) begin
            tone_cnt_q <= 10'h000;
            tone_q <= !tone_q;
        end else if (pre_tick) begin
            tone_cnt_q <= tone_cnt_q + 10'h001;
        end
    end

    // duration counter counts whole tone cycles
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            dur_cnt_q <= 8'h00;
        end else if (!run || dur_end) begin
            dur_cnt_q <= 8'h00;
        end else if (cycle_end) begin
            dur_cnt_q <= dur_cnt_q + 8'h01;
        end
    end

    // Outputs registered so the pins never glitch on a mux change
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            tone_o_q <= 1'b0;
            amp_o_q <= 1'b0;
        end else begin
            tone_o_q <= run && tone_q && (mix_q || pwm_hi);
            amp_o_q <= run && pwm_hi;
        end
    end

    assign AV_WAITREQUEST_O = wait_q;
    assign AV_READDATA_O = rdata_q;
    assign TONE_O = tone_o_q;
    assign AMP_O = amp_o_q;

    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RST_B_I);

    chk_disable_clears: assert property (
        !enable_q |=> (pre_cnt_q == 11'h000) && (tone_cnt_q == 10'h000) && (state_q == ST_IDLE))
        else $error("counters not cleared while disabled");
    chk_tone_alone: assert property (
        run && mix_q |=> TONE_O == $past(tone_q))
        else $error("tone pin not pure tone");
    chk_ready_cleared: assert property (
        cfg_wr |=> !data_ready_q)
        else $error("data ready survived a config write");
    chk_stop_noready: assert property (
        stop_evt |=> (state_q == ST_IDLE) && next_flag_q ##1 !TONE_O && !AMP_O)
        else $error("no stop on reload without data");
    chk_halt_now: assert property (
        halt_q && enable_q |=> (state_q == ST_IDLE) && (pre_cnt_q == 11'h000) ##1 !TONE_O)
        else $error("halt did not stop at once");
    chk_prescale_wrap: assert property (
        pre_tick |=> (pre_cnt_q == 11'h000))
        else $error("prescaler did not wrap");
    chk_pwm_full: assert property (
        run && (work_amp_q > buf_q.ps) |=> AMP_O)
        else $error("full duty not held");
    chk_tone_toggle: assert property (
        tone_edge |=> tone_q != $past(tone_q))
        else $error("tone did not toggle");
    chk_reload_copy: assert property (
        load_evt |=> (work_amp_q == $past(prog_q.amp)) && (buf_q == $past(prog_q)))
        else $error("reload copy wrong");
    chk_next_flag: assert property (
        load_evt |=> next_flag_q)
        else $error("next data flag not set");
endmodule : tone_sound_generator_config
`default_nettype wire

// ==== tsg_pkg.sv ====
// Package for the tone sound generator: register map, fields, types
`default_nettype none
package tsg_pkg;
    // Register indices; the byte address is four times the index
    localparam logic [4:0] IDX_CTRL = 5'h00;
    localparam logic [4:0] IDX_ENV = 5'h01;
    localparam logic [4:0] IDX_PSH = 5'h02;
    localparam logic [4:0] IDX_PSL = 5'h03;
    localparam logic [4:0] IDX_TONEH = 5'h04;
    localparam logic [4:0] IDX_TONEL = 5'h05;
    localparam logic [4:0] IDX_AMPH = 5'h06;
    localparam logic [4:0] IDX_AMPL = 5'h07;
    localparam logic [4:0] IDX_STEPH = 5'h08;
    localparam logic [4:0] IDX_STEPL = 5'h09;
    localparam logic [4:0] IDX_THRH = 5'h0A;
    localparam logic [4:0] IDX_THRL = 5'h0B;
    localparam logic [4:0] IDX_DUR = 5'h0C;
    localparam logic [4:0] IDX_NEXT = 5'h0E;
    localparam logic [4:0] IDX_WAMPH = 5'h10;
    localparam logic [4:0] IDX_WAMPL = 5'h11;
    localparam logic [4:0] IDX_DCNT = 5'h12;
    // Control and envelope field positions
    localparam int BIT_ENABLE = 7;
    localparam int BIT_MIX = 2;
    localparam int BIT_READY = 1;
    localparam int BIT_HALT = 0;
    localparam int BIT_ENV_EN = 7;
    localparam int BIT_SHAPE_LO = 1;
    localparam int BIT_ENV_DIR = 0;
    localparam int BIT_NEXT = 0;
    // Envelope shapes
    localparam logic [1:0] SHAPE_LINEAR = 2'h0;
    localparam logic [1:0] SHAPE_GONG = 2'h1;
    localparam logic [1:0] SHAPE_EXP = 2'h2;
    localparam logic [10:0] AMP_MAX = 11'h7FF;
    // Values after reset
    localparam logic CTRL_RESET = 1'b0;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
    // Generator states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN = 2'b10
    } gen_state_e;
    // Avalon-MM request from the master
    typedef struct packed {
        logic read;
        logic write;
        logic [4:0] address;
        logic [3:0] byteenable;
        logic [31:0] writedata;
    } av_req_s;
    // Sound configuration, programmed and buffered copies
    typedef struct packed {
        logic env_en;
        logic [1:0] env_shape;
        logic env_dir;
        logic [10:0] ps;
        logic [9:0] tone;
        logic [10:0] amp;
        logic [10:0] step;
        logic [10:0] thr;
        logic [7:0] dur;
    } cfg_s;
    localparam cfg_s CFG_RESET = '0;
endpackage : tsg_pkg
`default_nettype wire

// ==== tone_amp_listener.sv ====
// External amplifier model: measures run lengths on the tone and amplitude pins
`timescale 1ns/100ps
`default_nettype none
module tone_amp_listener (
    // Clock
    input wire logic clk_i,
    // Sound pins
    input wire logic tone_i,
    input wire logic amp_i,
    // Last completed runs, in clocks
    output logic [15:0] tone_high_o,
    output logic [15:0] amp_high_o,
    output logic [15:0] amp_low_o
);
    logic tone_q = 1'b0;
    logic amp_q = 1'b0;
    logic [15:0] tone_run_q = 16'h0000;
    logic [15:0] amp_run_q = 16'h0000;
    logic [15:0] tone_high_q = 16'h0000;
    logic [15:0] amp_high_q = 16'h0000;
    logic [15:0] amp_low_q = 16'h0000;
    // One process owns each result, so the ports have a single driver
    assign tone_high_o = tone_high_q;
    assign amp_high_o = amp_high_q;
    assign amp_low_o = amp_low_q;
    // A run is only reported once it has ended, so a stopped pin never reports
    always @(posedge clk_i) begin
        tone_q <= tone_i;
        amp_q <= amp_i;
        tone_run_q <= (tone_i === tone_q) ? tone_run_q + 16'h0001 : 16'h0001;
        amp_run_q <= (amp_i === amp_q) ? amp_run_q + 16'h0001 : 16'h0001;
        if (tone_q === 1'b1 && tone_i === 1'b0) begin
            tone_high_q <= tone_run_q;
        end
        if (amp_q === 1'b1 && amp_i === 1'b0) begin
            amp_high_q <= amp_run_q;
        end
        if (amp_q === 1'b0 && amp_i === 1'b1) begin
            amp_low_q <= amp_run_q;
        end
    end
endmodule : tone_amp_listener
`default_nettype wire

// ==== tone_sound_generator_config_bench.sv ====
// Self-checking bench for the tone sound generator
`timescale 1ns/100ps
`default_nettype none
module tone_sound_generator_config_bench;
    import tsg_pkg::*;
    logic clk;
    logic rst_b;
    av_req_s req;
    logic [31:0] rdata;
    logic wreq;
    logic tone;
    logic amp;
    logic [15:0] tone_high;
    logic [15:0] amp_high;
    logic [15:0] amp_low;
    logic [31:0] exp_q[$];
    int err_count;
    int checked;
    int ps;
    int tn;
    int am;
    logic [7:0] rnd;
    logic [2:0] seen;
    logic [4:0] cfg_idx [12] = '{IDX_ENV, IDX_PSH, IDX_PSL, IDX_TONEH, IDX_TONEL, IDX_AMPH,
        IDX_AMPL, IDX_STEPH, IDX_STEPL, IDX_THRH, IDX_THRL, IDX_DUR};
    logic [7:0] cfg_mask [12] = '{8'h87, 8'h07, 8'hFF, 8'h03, 8'hFF, 8'h07, 8'hFF, 8'h07,
        8'hFF, 8'h07, 8'hFF, 8'hFF};
    logic [7:0] env_code [7] = '{8'h80, 8'h82, 8'h84, 8'h83, 8'h85, 8'h86, 8'h04};
    logic [10:0] env_amp [7] = '{11'h155, 11'h000, 11'h000, 11'h400, 11'h400, 11'h155, 11'h400};
    logic [10:0] env_want [7] = '{11'h155, 11'h000, 11'h7FC, 11'h001, 11'h003, 11'h155, 11'h400};

    tone_sound_generator_config dut (.CLK_I(clk), .RST_B_I(rst_b), .AV_REQ_I(req),
        .AV_READDATA_O(rdata), .AV_WAITREQUEST_O(wreq), .TONE_O(tone), .AMP_O(amp));
    tone_amp_listener amp_model (.clk_i(clk), .tone_i(tone), .amp_i(amp),
        .tone_high_o(tone_high), .amp_high_o(amp_high), .amp_low_o(amp_low));

    task automatic test_done();
        $display("Summary: %0d mismatches in %0d checks", err_count, checked);
        if (err_count == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done

    task automatic check(input string what, input logic [31:0] got, input logic [31:0] want);
        checked++;
        if (got !== want) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, want, got);
        end
    endtask : check

    // Request held until waitrequest is sampled low, released at that edge
    task automatic access(input logic is_rd, input logic [4:0] idx, input logic [7:0] val);
        int n;
        n = 0;
        @(posedge clk);
        req <= '{read: is_rd, write: !is_rd, address: idx, byteenable: 4'hF,
            writedata: {24'h00_0000, val}};
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 40);
        req <= '0;
        if (n >= 40) begin
            err_count++;
            test_done();
        end
    endtask : access

    task automatic wr(input logic [4:0] idx, input logic [7:0] val);
        access(1'b0, idx, val);
    endtask : wr

    task automatic rd(input logic [4:0] idx, input logic [31:0] want);
        exp_q.push_back(want);
        access(1'b1, idx, 8'h00);
    endtask : rd

    // Decay needs a zero threshold, attack the top one, or the step never happens
    task automatic setup(input int p, input int t, input int a, input logic [7:0] env,
        input logic [7:0] ctrl);
        wr(IDX_CTRL, 8'h00);
        wr(IDX_ENV, env);
        wr(IDX_PSH, 8'(p >> 8));
        wr(IDX_PSL, 8'(p));
        wr(IDX_TONEH, 8'(t >> 8));
        wr(IDX_TONEL, 8'(t));
        wr(IDX_AMPH, 8'(a >> 8));
        wr(IDX_AMPL, 8'(a));
        wr(IDX_STEPH, 8'h00);
        wr(IDX_STEPL, 8'h00);
        wr(IDX_THRH, env[0] ? 8'h00 : 8'h07);
        wr(IDX_THRL, env[0] ? 8'h00 : 8'hFF);
        wr(IDX_DUR, 8'h00);
        wr(IDX_CTRL, ctrl);
    endtask : setup

    // Skips three cycles for the output latency, then gathers {any tone, any amp, all amp}
    task automatic watch(input int n, output logic [2:0] s);
        repeat (3) @(posedge clk);
        s = {1'b0, 1'b0, 1'b1};
        repeat (n) begin
            @(posedge clk);
            s = {s[2] | (tone === 1'b1), s[1] | (amp === 1'b1), s[0] & (amp === 1'b1)};
        end
    endtask : watch

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (req.read === 1'b1 && wreq === 1'b0) begin
            check("readdata", rdata, exp_q.pop_front());
        end
    end

    initial begin
        rst_b = 1'b0;
        req = '0;
        err_count = 0;
        checked = 0;
        void'($urandom(32'h2e49));
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        rd(IDX_CTRL, 32'h0000_0000);
        rd(5'h0D, 32'h0000_0000);
        wr(IDX_WAMPL, 8'hFF);
        rd(IDX_WAMPL, 32'h0000_0000);
        // Every configuration write drops data-ready
        foreach (cfg_idx[i]) begin
            rnd = 8'($urandom());
            wr(IDX_CTRL, 8'h02);
            rd(IDX_CTRL, 32'h0000_0002);
            wr(cfg_idx[i], rnd);
            rd(cfg_idx[i], {24'h00_0000, rnd & cfg_mask[i]});
            rd(IDX_CTRL, 32'h0000_0000);
        end
        // Random prescaler, tone and amplitude timing on the pins
        repeat (3) begin
            ps = $urandom_range(7, 1);
            tn = $urandom_range(3, 0);
            am = $urandom_range(ps, 1);
            setup(ps, tn, am, 8'h00, 8'h86);
            repeat (150) @(posedge clk);
            check("tone_high", 32'(tone_high), 32'((tn + 1) * (ps + 1)));
            check("amp_high", 32'(amp_high), 32'(am));
            check("amp_low", 32'(amp_low), 32'(ps + 1 - am));
            rd(IDX_WAMPL, 32'(am));
            rd(IDX_NEXT, 32'h0000_0001);
        end
        wr(IDX_CTRL, 8'h87);
        watch(20, seen);
        check("halt_pins", 32'(seen), 32'h0000_0000);
        wr(IDX_CTRL, 8'h06);
        watch(20, seen);
        check("off_pins", 32'(seen), 32'h0000_0000);
        rd(IDX_DCNT, 32'h0000_0000);
        // Mixed tone with zero amplitude stays silent, pure tone does not
        setup(3, 1, 0, 8'h00, 8'h82);
        watch(40, seen);
        check("mixed_pins", 32'(seen), 32'h0000_0000);
        setup(3, 1, 0, 8'h00, 8'h86);
        watch(40, seen);
        check("pure_pins", 32'(seen), 32'h0000_0004);
        setup(3, 1, 11'h7FF, 8'h00, 8'h86);
        watch(40, seen);
        check("full_duty", 32'(seen[1:0]), 32'h0000_0003);
        // Data-ready cleared while running stops at the duration end
        setup(0, 0, 1, 8'h00, 8'h86);
        wr(IDX_CTRL, 8'h84);
        repeat (10) @(posedge clk);
        watch(20, seen);
        check("stop_pins", 32'(seen), 32'h0000_0000);
        rd(IDX_NEXT, 32'h0000_0001);
        wr(IDX_NEXT, 8'h01);
        rd(IDX_NEXT, 32'h0000_0000);
        // Envelope shapes and directions settle on the working amplitude
        // second entry starts a gong attack from zero on purpose
        foreach (env_code[i]) begin
            setup(0, 0, env_amp[i], env_code[i], 8'h86);
            repeat (300) @(posedge clk);
            rd(IDX_WAMPH, {29'h0000_0000, env_want[i][10:8]});
            rd(IDX_WAMPL, {24'h00_0000, env_want[i][7:0]});
        end
        // Mid-run reset silences a running sound and clears the registers
        watch(10, seen);
        check("env_pins", 32'(seen[1:0]), 32'h0000_0003);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        check("reset_pins", {30'h0000_0000, tone, amp}, 32'h0000_0000);
        rst_b <= 1'b1;
        rd(IDX_CTRL, 32'h0000_0000);
        rd(IDX_WAMPL, 32'h0000_0000);
        wr(IDX_CTRL, 8'h00);
        test_done();
    end
endmodule : tone_sound_generator_config_bench
`default_nettype wire
